// File: rtl/ccr_defs.vh
// ccr_defs.vh: offsets, field positions, reset values and codes for the
// charger control and charge-current register pair.
// assumes: included by bare name from the rtl files of this block.
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// register offsets
`define CCR_ADDR_W          8
`define CCR_OFF_CTRL_ONE    8'h01
`define CCR_OFF_CUR_LIMIT   8'h02

// reset values
`define CCR_RST_CTRL_ONE    8'h1a
`define CCR_RST_CUR_LIMIT   8'h99

// charger_control_one fields
`define CCR_LL_OFF_BIT      7
`define CCR_WD_RESTART_BIT  6
`define CCR_BOOST_BIT       5
`define CCR_CHG_EN_BIT      4
`define CCR_SYSMIN_HI       3
`define CCR_SYSMIN_LO       1
`define CCR_MINBAT_BIT      0

// charge_current_limit fields
`define CCR_RSVD_BIT        7
`define CCR_FET_LOWR_BIT    6
`define CCR_CHARGE_CURRENT_CODE_HI         5
`define CCR_CHARGE_CURRENT_CODE_LO         0

// bits that a watchdog expiry returns to default
`define CCR_WD_MASK_ONE     8'h70
`define CCR_WD_MASK_CUR     8'hbf

// minimum system voltage table, millivolts per code
`define CCR_SYSMIN_0        12'ha28
`define CCR_SYSMIN_1        12'haf0
`define CCR_SYSMIN_2        12'hbb8
`define CCR_SYSMIN_3        12'hc80
`define CCR_SYSMIN_4        12'hd48
`define CCR_SYSMIN_5        12'hdac
`define CCR_SYSMIN_6        12'he10
`define CCR_SYSMIN_7        12'he74

// input fet switch-over threshold, milliamps
`define CCR_FET_THRESH_MA   12'h2bc

`endif

// File: rtl/ccr_charge_current_code_table.v
// ccr_charge_current_code_table.v: charge-current code to milliamps, stepped table.
// assumes: purely combinational, caller registers the result.
module ccr_charge_current_code_table (
  code,
  milliamps
);
  input  wire [5:0]  code;
  output reg  [11:0] milliamps;

  // --------------------------------------------------------------
  // piecewise linear decode
  // --------------------------------------------------------------
  // arithmetic per segment is cheaper than a 64-entry rom
  always @* begin
    if (code <= 6'h08) begin
      milliamps = {4'h0, code, 2'h0} + {6'h00, code};            // 5 ma
    end else if (code <= 6'h0f) begin
      milliamps = 12'h028 + (({6'h00, code - 6'h08}) * 12'h00a);  // 10 ma
    end else if (code <= 6'h17) begin
      milliamps = 12'h06e + (({6'h00, code - 6'h0f}) * 12'h014);  // 20 ma
    end else if (code <= 6'h20) begin
      milliamps = 12'h10e + (({6'h00, code - 6'h17}) * 12'h01e);  // 30 ma
    end else if (code <= 6'h30) begin
      milliamps = 12'h21c + (({6'h00, code - 6'h20}) * 12'h03c);  // 60 ma
    end else if (code <= 6'h3c) begin
      milliamps = 12'h5dc + (({6'h00, code - 6'h30}) * 12'h078);  // 120 ma
    end else begin
      milliamps = 12'hbb8;                                        // saturate
    end
  end
endmodule

// File: rtl/ccr_regs.v
// ccr_regs.v: charger control register and charge-current register.
// assumes: one 200 mhz clock, host register port on that clock,
// watchdog timer and expiry pulse live outside on the same clock,
// charge enable pin arrives asynchronously.
//
// Functional notes
// - bit 7 zero enables light-load pulse mode
// - control register at 0x01 resets to 0x1a
// - writing watchdog bit restarts the watchdog
// - watchdog bit clears itself, reads zero
// - boost bit wins over charge enable
// - charge needs enable bit and low pin
// - system minimum code maps 2.6 to 3.7 V
// - fet bit zero: high resistance below 700mA
// - current register at 0x02 resets to 0x99
// - charge current code bits 5:0, default 330mA
// - stepped current table, saturates at 3000mA
//
// Added by the designer: the strobed register port.
`include "ccr_defs.vh"

module ccr_regs (
  clk,
  reset_n,
  clk_en,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  watchdog_expired,
  charge_enable_pin_low,
  input_current_limit,
  watchdog_restart_pulse,
  light_load_pulse_enable,
  boost_enable,
  charge_enable,
  min_system_voltage_mv,
  min_battery_select,
  input_fet_high_resistance,
  charge_current_ma
);
  input  wire                    clk;
  input  wire                    reset_n;
  input  wire                    clk_en;
  input  wire [`CCR_ADDR_W-1:0]  reg_addr;
  input  wire [7:0]              reg_wdata;
  input  wire                    reg_wr;
  input  wire                    reg_rd;
  output reg  [7:0]              reg_rdata;
  input  wire                    watchdog_expired;
  input  wire                    charge_enable_pin_low;
  input  wire [11:0]             input_current_limit;
  output reg                     watchdog_restart_pulse;
  output reg                     light_load_pulse_enable;
  output reg                     boost_enable;
  output reg                     charge_enable;
  output reg  [11:0]             min_system_voltage_mv;
  output reg                     min_battery_select;
  output reg                     input_fet_high_resistance;
  output reg  [11:0]             charge_current_ma;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function [11:0] sysmin_mv;
    input [2:0] code;
    begin
      case (code)
        3'h0:    sysmin_mv = `CCR_SYSMIN_0;
        3'h1:    sysmin_mv = `CCR_SYSMIN_1;
        3'h2:    sysmin_mv = `CCR_SYSMIN_2;
        3'h3:    sysmin_mv = `CCR_SYSMIN_3;
        3'h4:    sysmin_mv = `CCR_SYSMIN_4;
        3'h5:    sysmin_mv = `CCR_SYSMIN_5;
        3'h6:    sysmin_mv = `CCR_SYSMIN_6;
        default: sysmin_mv = `CCR_SYSMIN_7;
      endcase
    end
  endfunction

  // restore masked bits to default, keep the rest
  function [7:0] wd_restore;
    input [7:0] cur;
    input [7:0] dflt;
    input [7:0] mask;
    begin
      wd_restore = (cur & ~mask) | (dflt & mask);
    end
  endfunction

  // --------------------------------------------------------------
  // pin synchroniser
  // --------------------------------------------------------------
  reg  ce_pin_meta_ff;
  reg  ce_pin_sync_ff;

  // pin is asynchronous; second stage is the only reader of the first
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ce_pin_meta_ff <= 1'b1;
      ce_pin_sync_ff <= 1'b1;
    end else if (clk_en) begin
      ce_pin_meta_ff <= charge_enable_pin_low;
      ce_pin_sync_ff <= ce_pin_meta_ff;
    end
  end

  // --------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------
  reg  [7:0] ctrl_one_ff;
  reg  [7:0] cur_limit_ff;
  reg  [7:0] nxt_ctrl_one;
  reg  [7:0] nxt_cur_limit;
  wire       wr_one = reg_wr && (reg_addr == `CCR_OFF_CTRL_ONE);
  wire       wr_cur = reg_wr && (reg_addr == `CCR_OFF_CUR_LIMIT);

  // host write beats expiry in the same cycle: a fresh restart is newer
  always @* begin
    nxt_ctrl_one  = ctrl_one_ff;
    nxt_cur_limit = cur_limit_ff;
    nxt_ctrl_one[`CCR_WD_RESTART_BIT] = 1'b0;
    if (watchdog_expired) begin
      nxt_ctrl_one  = wd_restore(nxt_ctrl_one, `CCR_RST_CTRL_ONE, `CCR_WD_MASK_ONE);
      nxt_cur_limit = wd_restore(cur_limit_ff, `CCR_RST_CUR_LIMIT, `CCR_WD_MASK_CUR);
    end
    if (wr_one) begin
      nxt_ctrl_one = reg_wdata;
    end
    if (wr_cur) begin
      nxt_cur_limit = reg_wdata;
    end
  end

  // reset to documented defaults
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_one_ff  <= `CCR_RST_CTRL_ONE;
      cur_limit_ff <= `CCR_RST_CUR_LIMIT;
    end else if (clk_en) begin
      ctrl_one_ff  <= nxt_ctrl_one;
      cur_limit_ff <= nxt_cur_limit;
    end
  end

  // --------------------------------------------------------------
  // read port
  // --------------------------------------------------------------
  // restart bit is masked out of the read data so it always reads back zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd && reg_addr == `CCR_OFF_CTRL_ONE) begin
        reg_rdata <= ctrl_one_ff & 8'hbf;
      end else if (reg_rd && reg_addr == `CCR_OFF_CUR_LIMIT) begin
        reg_rdata <= cur_limit_ff;
      end else begin
        reg_rdata <= 8'h00;                                        // unmapped
      end
    end
  end

  // --------------------------------------------------------------
  // decoded controls
  // --------------------------------------------------------------
  wire [11:0] charge_current_code_ma;

  ccr_charge_current_code_table u_charge_current_code (
    .code      (cur_limit_ff[`CCR_CHARGE_CURRENT_CODE_HI:`CCR_CHARGE_CURRENT_CODE_LO]),
    .milliamps (charge_current_code_ma)
  );

  wire boost_on = ctrl_one_ff[`CCR_BOOST_BIT];

  // all outputs registered; one cycle behind the register contents
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_restart_pulse    <= 1'b0;
      light_load_pulse_enable   <= 1'b1;
      boost_enable              <= 1'b0;
      charge_enable             <= 1'b0;
      min_system_voltage_mv     <= `CCR_SYSMIN_5;
      min_battery_select        <= 1'b0;
      input_fet_high_resistance <= 1'b0;
      charge_current_ma         <= 12'h000;
    end else if (clk_en) begin
      watchdog_restart_pulse    <= ctrl_one_ff[`CCR_WD_RESTART_BIT];
      light_load_pulse_enable   <= ~ctrl_one_ff[`CCR_LL_OFF_BIT];
      boost_enable              <= boost_on;
      charge_enable             <= ~boost_on && ctrl_one_ff[`CCR_CHG_EN_BIT] && ~ce_pin_sync_ff;
      min_system_voltage_mv     <= sysmin_mv(ctrl_one_ff[`CCR_SYSMIN_HI:`CCR_SYSMIN_LO]);
      min_battery_select        <= ctrl_one_ff[`CCR_MINBAT_BIT];
      input_fet_high_resistance <= ~cur_limit_ff[`CCR_FET_LOWR_BIT]
                                   && (input_current_limit < `CCR_FET_THRESH_MA);
      charge_current_ma         <= charge_current_code_ma;
    end
  end
endmodule

// File: bench/ccr_regs_monitor.sv
// ccr_regs_monitor.sv: port-level checks for the charger register pair.
// assumes: bound into ccr_regs, one clock, reset_n async active low.
`include "ccr_defs.vh"
module ccr_regs_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        watchdog_expired,
  input wire logic        charge_enable_pin_low,
  input wire logic [11:0] input_current_limit,
  input wire logic        watchdog_restart_pulse,
  input wire logic        light_load_pulse_enable,
  input wire logic        boost_enable,
  input wire logic        charge_enable,
  input wire logic        input_fet_high_resistance,
  input wire logic [11:0] charge_current_ma
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // --------------------------------------------------
  // accepted accesses to the control register
  // --------------------------------------------------
  wire logic restart_wr = clk_en && reg_wr && reg_addr == `CCR_OFF_CTRL_ONE && reg_wdata[6];
  sequence s_wr_one; clk_en && reg_wr && reg_addr == `CCR_OFF_CTRL_ONE; endsequence
  sequence s_rd_one; clk_en && reg_rd && reg_addr == `CCR_OFF_CTRL_ONE; endsequence
  // expiry with no write racing it, two cycles to reach outputs
  sequence s_expire; clk_en && watchdog_expired && !reg_wr ##1 clk_en && !reg_wr; endsequence
  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  AST_WD_READS_ZERO: assert property (s_rd_one |=> reg_rdata[6] == 1'b0)
    else $error("restart bit read back as one");
  // a restart write in the cycle before the pulse legally stretches the pulse
  AST_WD_PULSE_ONE: assert property (watchdog_restart_pulse && clk_en && !$past(restart_wr)
    |=> !watchdog_restart_pulse)
    else $error("restart pulse longer than one cycle");
  AST_WD_PULSE_CAUSE: assert property ($rose(watchdog_restart_pulse) |-> $past(restart_wr, 1) || $past(restart_wr, 2))
    else $error("restart pulse without a restart write");
  AST_LL_FOLLOWS: assert property (s_wr_one |-> ##2 light_load_pulse_enable == !$past(reg_wdata[7], 2))
    else $error("light load enable not the inverse of bit 7");
  AST_BOOST_WINS: assert property (boost_enable |-> !charge_enable)
    else $error("charge enabled while boost on");
  AST_CHG_NEEDS_PIN: assert property ($rose(charge_enable) |-> !$past(charge_enable_pin_low, 3))
    else $error("charge enabled with pin high");
  AST_EXPIRY_DEFAULTS: assert property (s_expire |=> !boost_enable && charge_current_ma == 12'h14a)
    else $error("expiry did not restore defaults");
  // output is registered: compare with the limit seen at the updating edge
  AST_FET_LIMIT: assert property (input_fet_high_resistance && $past(clk_en)
    |-> $past(input_current_limit) < `CCR_FET_THRESH_MA)
    else $error("high fet resistance at or above threshold");
endmodule
bind ccr_regs ccr_regs_monitor u_mon (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .watchdog_expired(watchdog_expired), .charge_enable_pin_low(charge_enable_pin_low),
  .input_current_limit(input_current_limit), .watchdog_restart_pulse(watchdog_restart_pulse),
  .light_load_pulse_enable(light_load_pulse_enable), .boost_enable(boost_enable),
  .charge_enable(charge_enable), .input_fet_high_resistance(input_fet_high_resistance),
  .charge_current_ma(charge_current_ma));

// File: bench/tb_ccr_regs.sv
// tb_ccr_regs.sv: self-checking bench for the charger register pair.
// assumes: ccr_regs and ccr_defs.vh on the include path, 200 mhz clock.
`include "ccr_defs.vh"
module tb_ccr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        watchdog_expired = 1'b0, charge_enable_pin_low = 1'b0, seen;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, v;
  logic [11:0] input_current_limit = 12'd500;
  wire  [7:0]  reg_rdata;
  wire  [11:0] min_system_voltage_mv, charge_current_ma;
  wire         watchdog_restart_pulse, light_load_pulse_enable, boost_enable, charge_enable;
  wire         min_battery_select, input_fet_high_resistance;
  int          miscompares = 0, checks_done = 0, cycles = 0;
  ccr_regs dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .watchdog_expired(watchdog_expired),
    .charge_enable_pin_low(charge_enable_pin_low), .input_current_limit(input_current_limit),
    .watchdog_restart_pulse(watchdog_restart_pulse), .light_load_pulse_enable(light_load_pulse_enable),
    .boost_enable(boost_enable), .charge_enable(charge_enable), .min_system_voltage_mv(min_system_voltage_mv),
    .min_battery_select(min_battery_select), .input_fet_high_resistance(input_fet_high_resistance),
    .charge_current_ma(charge_current_ma));
  // --------------------------------------------------
  // clock and hang guard
  // --------------------------------------------------
  always #2.5 clk = ~clk;
  // whole run is well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one-cycle strobes, released at the edge that takes them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // stepped current table, widening steps, flat top
  function automatic logic [11:0] charge_current_code_ma(input int c);
    if (c <= 8) return 12'(5 * c);
    if (c <= 15) return 12'(40 + 10 * (c - 8));
    if (c <= 23) return 12'(110 + 20 * (c - 15));
    if (c <= 32) return 12'(270 + 30 * (c - 23));
    if (c <= 48) return 12'(540 + 60 * (c - 32));
    if (c <= 60) return 12'(1500 + 120 * (c - 48));
    return 12'd3000;
  endfunction
  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    rd(8'h01, v); chk(v, 8'h1a);
    rd(8'h02, v); chk(v, 8'h99);
    chk(light_load_pulse_enable, 1);
    chk(charge_enable, 1);
    chk(min_system_voltage_mv, 12'd3500);
    chk(charge_current_ma, 12'd330);
    chk(input_fet_high_resistance, 1);
    chk(min_battery_select, 0);
    for (int c = 0; c < 8; c++) begin
      wr(8'h01, 8'h10 | 8'(c << 1)); settle();
      chk(min_system_voltage_mv, c < 5 ? 12'(2600 + 200 * c) : 12'(3000 + 100 * c));
    end
    for (int c = 0; c < 64; c++) begin
      wr(8'h02, 8'h80 | 8'(c)); settle();
      chk(charge_current_ma, charge_current_code_ma(c));
    end
    // restart write with boost on: pulse, bit reads zero, boost wins
    wr(8'h01, 8'h7b);
    seen = 1'b0;
    repeat (4) begin
      #1 seen = seen | watchdog_restart_pulse;
      @(posedge clk);
    end
    chk(seen, 1);
    rd(8'h01, v); chk(v, 8'h3b);
    settle(); chk(boost_enable, 1); chk(charge_enable, 0);
    wr(8'h01, 8'h90); settle(); chk(light_load_pulse_enable, 0); chk(charge_enable, 1);
    charge_enable_pin_low <= 1'b1; settle(); settle(); chk(charge_enable, 0);
    charge_enable_pin_low <= 1'b0;
    // expiry keeps register-reset-only bits
    wr(8'h01, 8'hef); wr(8'h02, 8'h45); settle(); chk(input_fet_high_resistance, 0);
    @(posedge clk) watchdog_expired <= 1'b1;
    @(posedge clk) watchdog_expired <= 1'b0;
    settle();
    rd(8'h01, v); chk(v, 8'h9f);
    rd(8'h02, v); chk(v, 8'hd9);
    chk(min_battery_select, 1);
    chk(light_load_pulse_enable, 0);
    chk(min_system_voltage_mv, 12'd3700);
    chk(charge_current_ma, 12'd330);
    // threshold boundary: 700 is not below
    wr(8'h02, 8'h19); settle(); chk(input_fet_high_resistance, 1);
    input_current_limit <= 12'd700; settle(); chk(input_fet_high_resistance, 0);
    // unmapped place and frozen clock enable
    wr(8'h03, 8'hff); rd(8'h03, v); chk(v, 8'h00);
    clk_en <= 1'b0; wr(8'h01, 8'h00); clk_en <= 1'b1;
    rd(8'h01, v); chk(v, 8'h9f);
    conclude();
  end
endmodule
